//--- hdl/color_palette_lookup.sv
// Functional notes
// RULE1 - select 00 pointer load mode, 11 pointer readback, 10 staging buffer, 01 mask
// RULE2 - palette holds 256 entries of 18 bits feeding three 6-bit channels
// RULE3 - host accesses run independently of the pixel clock and pixel stream
// RULE4 - load: pointer write, three bytes, store entry then increment pointer
// RULE5 - staging buffer writes use only data bits 5 to 0
// RULE6 - staging buffer reads give 6-bit value, top two bits zero
// RULE7 - readback pointer write copies addressed entry to staging, then increments pointer
// RULE8 - after third byte read, next entry loads into staging, pointer increments
// RULE9 - components move red, green, blue; device tracks the position
// RULE10 - pointer write mid-sequence restarts at the first component
// RULE11 - mask ones force matching pixel index bits to zero before lookup
// RULE12 - mask touches only the pixel path, never host palette addressing
// RULE13 - mask is a byte register read and written with select 01
// RULE14 - index and blank caught each pixel clock rise, colors after three stages; code drops rises while the output buffer is full
// RULE15 - blank asserted forces all three channel outputs to zero
// RULE16 - host palette transfer wins the lookup; pixel may show pointer entry
// RULE17 - write data captured at the rising edge of the write strobe
// RULE18 - select lines sampled at the falling edge of either strobe
// RULE19 - data bus driven only while read strobe is low
// RULE20 - host spaces accesses three pixel clocks, six after readback
// RULE21 - host strobes are synchronised before transfers and increments
`timescale 1ns/1ps
module color_palette_lookup (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic pclk_i,
  input wire logic [palette_pkg::IDX_W-1:0] pixel_index_in_i,
  input wire logic blank_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic reg_select_lo_i,
  input wire logic reg_select_hi_i,
  input wire logic [palette_pkg::DATA_W-1:0] host_data_bus_i,
  output logic [palette_pkg::DATA_W-1:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic [palette_pkg::COMP_W-1:0] red_o,
  output logic [palette_pkg::COMP_W-1:0] green_o,
  output logic [palette_pkg::COMP_W-1:0] blue_o,
  output logic pix_ready_o,
  output logic color_valid_o,
  input wire logic color_ready_i,
  output logic [palette_pkg::COLOR_W-1:0] color_data_o
);
  import palette_pkg::*;

  typedef struct packed {
    logic [PAL_DEPTH-1:0][COLOR_W-1:0] pal;
    logic [IDX_W-1:0] ptr;
    logic [COLOR_W-1:0] stage;
    logic [IDX_W-1:0] mask;
    logic [1:0] comp;
    logic read_mode;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] data_hold;
    logic wr_prev;
    logic rd_prev;
    logic pclk_prev;
    logic [IDX_W-1:0] p1_idx;
    logic p1_blank_n;
    logic [COLOR_W-1:0] p2_rgb;
    logic p2_blank_n;
    logic [COLOR_W-1:0] p3_rgb;
    logic push_vld;
  } state_t;

  state_t r_reg;
  state_t r_next;

  logic wr_lvl;
  logic rd_lvl;
  logic pclk_lvl;
  logic blank_lvl;
  logic [SEL_W-1:0] sel_lvl;
  logic [IDX_W-1:0] idx_lvl;
  logic [DATA_W-1:0] data_lvl;
  logic fifo_in_ready;

  // every host and pixel pin crosses through four flops; color_ready_i goes to the buffer unsynchronised
  pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_wr ( // RULE21
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(wr_n_i),
    .q_o(wr_lvl)
  );

  pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_rd ( // RULE21
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(rd_n_i),
    .q_o(rd_lvl)
  );

  pin_sync #(.W(1), .RST_VAL(1'b0)) u_sync_pclk (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(pclk_i),
    .q_o(pclk_lvl)
  );

  pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_blank (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(blank_n_i),
    .q_o(blank_lvl)
  );

  pin_sync #(.W(SEL_W), .RST_VAL(2'h0)) u_sync_sel (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i({reg_select_lo_i, reg_select_hi_i}),
    .q_o(sel_lvl)
  );

  pin_sync #(.W(IDX_W), .RST_VAL(8'h00)) u_sync_idx (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(pixel_index_in_i),
    .q_o(idx_lvl)
  );

  pin_sync #(.W(DATA_W), .RST_VAL(8'h00)) u_sync_data (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(host_data_bus_i),
    .q_o(data_lvl)
  );

  // output stream buffer; a full buffer holds the pixel pipeline
  stream_fifo #(.W(COLOR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(r_reg.push_vld),
    .in_ready_o(fifo_in_ready),
    .in_data_i(r_reg.p3_rgb),
    .out_valid_o(color_valid_o),
    .out_ready_i(color_ready_i),
    .out_data_o(color_data_o)
  );

  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic pclk_rise;
  logic advance;
  logic host_pal;
  logic [IDX_W-1:0] look_addr;
  logic [COMP_W-1:0] comp_val;
  logic color_store;
  logic ptr_read_load;
  logic read_reload;
  logic [IDX_W-1:0] host_addr;
  logic [IDX_W-1:0] masked_idx;
  logic [COLOR_W-1:0] store_word;
  logic [COLOR_W-1:0] look_word;

  assign wr_fall = r_reg.wr_prev && !wr_lvl;
  assign wr_rise = !r_reg.wr_prev && wr_lvl;
  assign rd_fall = r_reg.rd_prev && !rd_lvl;
  assign rd_rise = !r_reg.rd_prev && rd_lvl;
  assign pclk_rise = !r_reg.pclk_prev && pclk_lvl;
  // hold a stage while the previous push is pending or the buffer is full
  assign advance = pclk_rise && fifo_in_ready && !r_reg.push_vld;
  // a stalled rise is dropped, not queued; pix_ready_o warns the source

  // host palette transfer in this cycle steals the lookup port
  assign color_store = wr_rise && r_reg.sel == SEL_COLOR && r_reg.comp == COMP_BLUE;
  assign ptr_read_load = wr_rise && r_reg.sel == SEL_PTR_READ;
  assign read_reload = rd_rise && r_reg.sel == SEL_COLOR && r_reg.comp == COMP_BLUE
    && r_reg.read_mode;
  assign host_pal = color_store || ptr_read_load || read_reload;

  // the pointer load reads the entry it is given, not the old pointer
  always_comb begin
    host_addr = r_reg.ptr;
    if (ptr_read_load) begin
      host_addr = r_reg.data_hold;
    end
  end
  assign look_addr = host_pal ? host_addr : r_reg.p1_idx; // RULE16
  assign look_word = r_reg.pal[look_addr]; // RULE2

  // mask acts on the pixel side only; host addressing stays whole
  assign masked_idx = idx_lvl & ~r_reg.mask; // RULE11 RULE12
  assign store_word = {r_reg.stage[RED_LSB +: COMP_W], r_reg.stage[GREEN_LSB +: COMP_W],
    r_reg.data_hold[COMP_W-1:0]};

  always_comb begin
    case (r_reg.comp)
      COMP_RED: comp_val = r_reg.stage[RED_LSB +: COMP_W];
      COMP_GREEN: comp_val = r_reg.stage[GREEN_LSB +: COMP_W];
      default: comp_val = r_reg.stage[BLUE_LSB +: COMP_W];
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.wr_prev = wr_lvl;
    r_next.rd_prev = rd_lvl;
    r_next.pclk_prev = pclk_lvl;
    r_next.push_vld = 1'b0;

    if (wr_fall || rd_fall) begin
      r_next.sel = sel_lvl; // RULE18
    end
    // data may leave right after the strobe rises, so keep the last value seen while low
    if (!wr_lvl) begin
      r_next.data_hold = data_lvl;
    end

    if (wr_rise) begin // RULE17
      case (r_reg.sel) // RULE1
        SEL_PTR_LOAD: begin
          r_next.ptr = r_reg.data_hold;
          r_next.comp = COMP_RED; // RULE10
          r_next.read_mode = 1'b0;
        end
        SEL_PTR_READ: begin
          r_next.stage = r_reg.pal[r_reg.data_hold]; // RULE7
          r_next.ptr = r_reg.data_hold + PTR_STEP;
          r_next.comp = COMP_RED; // RULE10
          r_next.read_mode = 1'b1;
        end
        SEL_COLOR: begin
          // upper two bits dropped
          case (r_reg.comp) // RULE9
            COMP_RED: r_next.stage[RED_LSB +: COMP_W] = r_reg.data_hold[COMP_W-1:0]; // RULE5
            COMP_GREEN: r_next.stage[GREEN_LSB +: COMP_W] = r_reg.data_hold[COMP_W-1:0];
            default: r_next.stage[BLUE_LSB +: COMP_W] = r_reg.data_hold[COMP_W-1:0];
          endcase
          if (r_reg.comp == COMP_BLUE) begin
            // store at the pointer, never the masked index
            r_next.pal[r_reg.ptr] = store_word; // RULE4 RULE12
            r_next.ptr = r_reg.ptr + PTR_STEP;
            r_next.comp = COMP_RED;
          end else begin
            r_next.comp = r_reg.comp + COMP_STEP;
          end
        end
        default: begin
          r_next.mask = r_reg.data_hold; // RULE13
        end
      endcase
    end

    if (rd_fall) begin
      case (sel_lvl)
        SEL_COLOR: r_next.dout = {PAD_ZERO, comp_val}; // RULE6
        SEL_MASK: r_next.dout = r_reg.mask; // RULE13
        default: r_next.dout = r_reg.ptr;
      endcase
    end

    if (rd_rise && r_reg.sel == SEL_COLOR) begin // RULE9
      if (r_reg.comp == COMP_BLUE) begin
        r_next.comp = COMP_RED;
        if (r_reg.read_mode) begin
          r_next.stage = r_reg.pal[r_reg.ptr]; // RULE8
          r_next.ptr = r_reg.ptr + PTR_STEP;
        end
      end else begin
        r_next.comp = r_reg.comp + COMP_STEP;
      end
    end

    // pixel path runs on detected pixel clock rises, apart from host timing
    if (advance) begin // RULE3 RULE14
      r_next.p1_idx = masked_idx; // RULE11
      r_next.p1_blank_n = blank_lvl;
      r_next.p2_rgb = look_word; // RULE2
      r_next.p2_blank_n = r_reg.p1_blank_n;
      r_next.p3_rgb = r_reg.p2_blank_n ? r_reg.p2_rgb : '0; // RULE15
      r_next.push_vld = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r_reg <= '0;
      r_reg.ptr <= PTR_RST;
      r_reg.mask <= MASK_RST;
      r_reg.wr_prev <= 1'b1;
      r_reg.rd_prev <= 1'b1;
      r_reg.p1_blank_n <= 1'b0;
      r_reg.p2_blank_n <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign host_data_bus_o = r_reg.dout;
  // released as soon as the read strobe is seen high again
  assign host_data_bus_oe_o = !rd_lvl && !r_reg.rd_prev; // RULE19

  // one slice per channel of the third stage
  localparam int CHANS = COLOR_W / COMP_W;
  logic [CHANS-1:0][COMP_W-1:0] chan;
  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    assign chan[c] = r_reg.p3_rgb[c * COMP_W +: COMP_W];
  end
  assign red_o = chan[RED_LSB / COMP_W];
  assign green_o = chan[GREEN_LSB / COMP_W];
  assign blue_o = chan[BLUE_LSB / COMP_W];
  assign pix_ready_o = fifo_in_ready;
endmodule

//--- hdl/palette_pkg.sv
package palette_pkg;
  localparam int IDX_W = 8;
  localparam int COMP_W = 6;
  localparam int COLOR_W = 18;
  localparam int PAL_DEPTH = 256;
  localparam int DATA_W = 8;
  localparam int SEL_W = 2;
  localparam int FIFO_DEPTH = 32;
  // select code is {reg_select_lo, reg_select_hi}
  localparam logic [1:0] SEL_PTR_LOAD = 2'h0;
  localparam logic [1:0] SEL_PTR_READ = 2'h3;
  localparam logic [1:0] SEL_COLOR = 2'h2;
  localparam logic [1:0] SEL_MASK = 2'h1;
  // component positions inside the staging buffer
  localparam int RED_LSB = 12;
  localparam int GREEN_LSB = 6;
  localparam int BLUE_LSB = 0;
  localparam logic [1:0] COMP_RED = 2'h0;
  localparam logic [1:0] COMP_GREEN = 2'h1;
  localparam logic [1:0] COMP_BLUE = 2'h2;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [1:0] PAD_ZERO = 2'h0;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [1:0] COMP_STEP = 2'h1;
endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t r_reg;
  sync_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // s1 feeds only s2; accept once stages two and three agree
    if (r_reg.s2 == r_reg.s3) begin
      r_next.q = r_reg.s3;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule

//--- hdl/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } fifo_t;

  fifo_t r_reg;
  fifo_t r_next;
  logic full;
  logic empty;

  assign empty = (r_reg.wptr == r_reg.rptr);
  assign full = (r_reg.wptr[AW] != r_reg.rptr[AW]) && (r_reg.wptr[AW-1:0] == r_reg.rptr[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = r_reg.mem[r_reg.rptr[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (in_valid_i && !full) begin
      r_next.mem[r_reg.wptr[AW-1:0]] = in_data_i;
      r_next.wptr = r_reg.wptr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      r_next.rptr = r_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

//--- sim/color_palette_lookup_properties.sv
`timescale 1ns/1ps
module color_palette_lookup_properties (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic pclk_i,
  input wire logic blank_n_i,
  input wire logic rd_n_i,
  input wire logic [palette_pkg::DATA_W-1:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  input wire logic [palette_pkg::COMP_W-1:0] red_o,
  input wire logic [palette_pkg::COMP_W-1:0] green_o,
  input wire logic [palette_pkg::COMP_W-1:0] blue_o,
  input wire logic pix_ready_o,
  input wire logic color_valid_o,
  input wire logic color_ready_i,
  input wire logic [palette_pkg::COLOR_W-1:0] color_data_o
);
  import palette_pkg::*;
  logic pclk_reg;
  logic [7:0] since_reg;
  logic [2:0] blanks_reg;
  wire pclk_rise = pclk_i && !pclk_reg;
  always_ff @(posedge ref_clk_i) begin
    pclk_reg <= pclk_i;
    if (srst_i) since_reg <= 8'hFF;
    else if (pclk_rise) since_reg <= 8'h00;
    else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
    // blank seen at the rise, as the pipeline samples it
    if (srst_i) blanks_reg <= 3'h0;
    else if (pclk_rise) blanks_reg <= blank_n_i ? 3'h0 : blanks_reg + {2'h0, blanks_reg != 3'h7};
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  oe_idle_a: assert property (rd_n_i [*6] |-> !host_data_bus_oe_o)
    else $error("bus driven without read");
  oe_drive_a: assert property (!rd_n_i [*7] |-> host_data_bus_oe_o)
    else $error("bus not driven in read");
  rd_hold_a: assert property (host_data_bus_oe_o && $past(host_data_bus_oe_o) |-> $stable(host_data_bus_o))
    else $error("read data moved");
  blank_zero_a: assert property (blanks_reg >= 3'h4 |-> {red_o, green_o, blue_o} == 18'h00000)
    else $error("color while blanked");
  rgb_cause_a: assert property ($changed({red_o, green_o, blue_o}) |-> since_reg <= 8'h06)
    else $error("color moved without pixel clock");
  push_cause_a: assert property ($rose(color_valid_o) |-> since_reg <= 8'h08)
    else $error("word without pixel clock");
  fifo_hold_a: assert property (color_valid_o && !color_ready_i |=> color_valid_o && $stable(color_data_o))
    else $error("stream word dropped");
  full_valid_a: assert property (!pix_ready_o |-> color_valid_o)
    else $error("stall with empty buffer");
  reset_clear_a: assert property ($fell(srst_i) |-> !color_valid_o && !host_data_bus_oe_o)
    else $error("state after reset");
  cover property (blanks_reg == 3'h7);
  cover property (!pix_ready_o);
  cover property (color_valid_o && color_ready_i);
endmodule
bind color_palette_lookup color_palette_lookup_properties u_props (.ref_clk_i, .srst_i, .pclk_i,
  .blank_n_i, .rd_n_i, .host_data_bus_o, .host_data_bus_oe_o, .red_o, .green_o, .blue_o,
  .pix_ready_o, .color_valid_o, .color_ready_i, .color_data_o);

//--- sim/color_palette_lookup_tb.sv
`timescale 1ns/1ps
module color_palette_lookup_tb;
  import palette_pkg::*;
  logic clk, srst, pclk, blank_n, wr_n, rd_n, oe, valid, ready, pix_ready, fill;
  logic [1:0] sel;
  logic [7:0] idx, drv, dout, bus, base, a, m;
  logic [5:0] r, g, b;
  logic [17:0] cdata;
  logic [17:0] pal [256];
  logic [17:0] exp_q [$];
  logic [31:0] seed = 32'h2AB9;
  int bad_count, total_checks, pops, cyc, pops_base;
  assign bus = oe ? dout : drv;
  pixel_source u_src (.pclk_o(pclk), .index_o(idx), .blank_n_o(blank_n));
  color_palette_lookup u_dut (.ref_clk_i(clk), .srst_i(srst), .pclk_i(pclk),
    .pixel_index_in_i(idx), .blank_n_i(blank_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .reg_select_lo_i(sel[1]), .reg_select_hi_i(sel[0]), .host_data_bus_i(bus),
    .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .red_o(r), .green_o(g), .blue_o(b),
    .pix_ready_o(pix_ready), .color_valid_o(valid), .color_ready_i(ready),
    .color_data_o(cdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // wide gap covers the longer spacing after readbacks
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    sel = s;
    drv = d;
    wr_n = 1'b0;
    tick(8);
    wr_n = 1'b1;
    tick(2);
    drv = ~d;
    tick(50);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e, input string n);
    sel = s;
    rd_n = 1'b0;
    tick(8);
    chk(n, 18'(bus), 18'(e));
    rd_n = 1'b1;
    tick(6);
    chk("bus release", 18'(oe), 18'h00000);
    tick(46);
  endtask
  task automatic wr_color(input logic [7:0] p);
    logic [7:0] d [3];
    foreach (d[k]) begin
      d[k] = 8'(rnd());
      wr(SEL_COLOR, d[k]);
    end
    pal[p] = {d[0][5:0], d[1][5:0], d[2][5:0]};
  endtask
  task automatic rd_entry(input logic [7:0] p);
    for (int k = 0; k < 3; k++) rd(SEL_COLOR, {2'h0, 6'(pal[p] >> (12 - 6 * k))}, "byte");
  endtask
  task automatic burst(input int n);
    logic [7:0] i;
    logic bl;
    logic [17:0] want [$];
    want = exp_q;
    for (int k = 0; k < n + 2; k++) begin
      i = (base + 8'(k % 4)) | (8'(rnd()) & m);
      bl = k < n && rnd() % 4 != 0;
      exp_q.push_back(bl ? pal[i & ~m] : 18'h00000);
      want.push_back(exp_q[$]);
      u_src.send(i, bl);
      chk("pixel out", {r, g, b}, want[k]);
    end
    for (int t = 0; t < 400 && exp_q.size() > 2; t++) tick(1);
    chk("words left", 18'(exp_q.size()), 18'h00002);
  endtask
  task automatic do_reset();
    srst = 1'b1;
    tick(10);
    srst = 1'b0;
    exp_q = '{18'h00000, 18'h00000};
    tick(6);
  endtask
  always @(posedge clk) begin
    if (!srst && valid && ready) begin
      pops++;
      chk("color word", cdata, exp_q.size() ? exp_q.pop_front() : 18'h00000);
    end
  end
  always @(posedge clk) #2 ready = !fill && rnd() % 4 != 0;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {srst, wr_n, rd_n, sel, drv, fill} = {3'h7, 2'h0, 8'h00, 1'b0};
    foreach (pal[k]) pal[k] = 18'h00000;
    do_reset();
    rd(SEL_MASK, MASK_RST, "mask reset");
    rd(SEL_PTR_LOAD, PTR_RST, "pointer reset");
    fill = 1'b1;
    repeat (36) u_src.send(8'(rnd()), 1'b0);
    chk("ready when full", 18'(pix_ready), 18'h00000);
    pops_base = pops;
    fill = 1'b0;
    tick(200);
    chk("buffer words", 18'(pops - pops_base), 18'(FIFO_DEPTH));
    chk("drained", 18'(valid), 18'h00000);
    do_reset();
    base = 8'(rnd()) & 8'hFC;
    a = base + 8'h10;
    wr(SEL_PTR_LOAD, base);
    for (int e = 0; e < 4; e++) wr_color(base + 8'(e));
    rd(SEL_PTR_LOAD, base + 8'h04, "pointer step");
    wr(SEL_PTR_LOAD, a);
    wr(SEL_COLOR, 8'h3F);
    wr(SEL_COLOR, 8'h3F);
    wr(SEL_PTR_LOAD, a + 8'h01);
    wr_color(a + 8'h01);
    rd(SEL_PTR_READ, a + 8'h02, "pointer abort");
    m = (8'(rnd()) | 8'hF0) & ~base & 8'hFC;
    wr(SEL_MASK, m);
    rd(SEL_MASK, m, "mask");
    wr(SEL_PTR_READ, base);
    rd(SEL_COLOR, {2'h0, pal[base][17:12]}, "first red");
    wr(SEL_PTR_READ, a);
    rd_entry(a);
    rd_entry(a + 8'h01);
    rd(SEL_PTR_READ, a + 8'h03, "pointer reads");
    wr(SEL_PTR_READ, base);
    for (int e = 0; e < 4; e++) rd_entry(base + 8'(e));
    burst(40);
    m = 8'h00;
    wr(SEL_MASK, m);
    burst(24);
    end_of_test();
  end
endmodule

//--- sim/pixel_source.sv
`timescale 1ns/1ps
module pixel_source (
  output logic pclk_o,
  output logic [palette_pkg::IDX_W-1:0] index_o,
  output logic blank_n_o
);
  initial begin
    pclk_o = 1'b0;
    index_o = 8'h00;
    blank_n_o = 1'b1;
  end
  // clock stands still between calls
  // pins move at the caller's edge offset; index scrambles at the clock fall
  task automatic send(input logic [7:0] idx, input logic bl_n);
    index_o = idx;
    blank_n_o = bl_n;
    #50 pclk_o = 1'b1;
    #100 pclk_o = 1'b0;
    index_o = ~idx;
    blank_n_o = ~bl_n;
    #50;
  endtask
endmodule
